/* llcc_top.sv */
// Purpose: APB register file and control of a frequency-locked loop
// Assumes: pclk 250 MHz; loop clock and reference presence arrive as pins
// Notes:   Shadow config applied on update strobe while the loop runs

`timescale 1ns/1ns

// Operation
// - System clock choice: doubled or plain output
// - Pin clock divider, ratios 1 to 127
// - Output equals reference over divider times ratio
// - Ratio fields are plain unsigned integers
// - Running loop applies fields on update bit
// - Hold freezes feedback and keeps frequency
// - Lost reference free-runs; relocks without hold
// - Lock and detect fields at documented bits
// - Reference divider codes divide by one, two
// - Reference source codes select clocks or none
// - Gain fields exponent coding; fine 1111 off
module llcc_top #(
    parameter int DIV_W = 7
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [15:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire logic                 ref_present,
    input  wire logic                 loop_clk_tick,
    output llcc_pkg::llcc_cfg_t       loop_cfg,
    output llcc_pkg::llcc_ctl_t       loop_ctl,
    output logic                      gpio_clk_out,
    output logic                      sys_clk_double
);

    llcc_pkg::llcc_state_t state;
    llcc_pkg::llcc_state_t next_state;

    // ----------------------------------------------------------------
    // Field packing helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] pack_reflock(input llcc_pkg::llcc_cfg_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[31:28] = c.lock_detect_threshold;
        w[llcc_pkg::BIT_LOCKDET]  = c.lock_detect_enable;
        w[llcc_pkg::BIT_PHASEDET] = c.phase_detect_enable;
        w[llcc_pkg::BIT_REFDET]   = c.reference_detect_enable;
        w[17:16] = c.reference_divider;
        w[15:12] = c.reference_source_select;
        w[9:0]   = c.integer_multiplier;
        return w;
    endfunction

    function automatic logic [31:0] pack_gains(input llcc_pkg::llcc_cfg_t c);
        return {c.phase_gain_fine, c.phase_gain_coarse, c.freq_gain_fine,
                c.freq_gain_coarse, 16'h0000};
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic        wr;
        logic        rd;
        logic        upd;
        logic        ref_ok;
        logic [31:0] d;
        next_state = state;
        // Writes commit at the edge where the master sees pready high
        wr  = psel && penable && pwrite && state.pready;
        rd  = psel && penable && !pwrite && !state.pready;
        d   = pwdata;
        upd = 1'b0;

        // One wait state per access phase, acknowledged next edge
        next_state.pready  = psel && penable && !state.pready;
        next_state.pslverr = 1'b0;
        // Write errors go out with the ack, one edge ahead of the commit
        if (psel && penable && pwrite && !state.pready) begin
            case (paddr)
                llcc_pkg::ADDR_ENABLE, llcc_pkg::ADDR_REFLOCK, llcc_pkg::ADDR_RATIO,
                llcc_pkg::ADDR_GAINS, llcc_pkg::ADDR_CLKOUT, llcc_pkg::ADDR_STATUS:
                    next_state.pslverr = 1'b0;
                default: next_state.pslverr = 1'b1;
            endcase
        end
        next_state.prdata  = 32'h0000_0000;

        // Config writes go to shadow storage first; enable and clock-out fields apply directly
        if (wr) begin
            case (paddr)
                llcc_pkg::ADDR_ENABLE: begin
                    next_state.loop_enable_bit = d[llcc_pkg::BIT_ENABLE];
                    next_state.loop_hold_bit   = d[llcc_pkg::BIT_HOLD];
                    upd = d[llcc_pkg::BIT_UPDATE];
                end
                llcc_pkg::ADDR_REFLOCK: begin
                    next_state.shadow.lock_detect_threshold   = d[31:28];
                    next_state.shadow.lock_detect_enable      = d[llcc_pkg::BIT_LOCKDET];
                    next_state.shadow.phase_detect_enable     = d[llcc_pkg::BIT_PHASEDET];
                    next_state.shadow.reference_detect_enable = d[llcc_pkg::BIT_REFDET];
                    next_state.shadow.reference_divider       = d[17:16];
                    next_state.shadow.reference_source_select = d[15:12];
                    next_state.shadow.integer_multiplier      = d[9:0];
                end
                llcc_pkg::ADDR_RATIO: begin
                    next_state.shadow.fraction_denominator = d[31:16];
                    next_state.shadow.fraction_numerator   = d[15:0];
                end
                llcc_pkg::ADDR_GAINS: begin
                    next_state.shadow.phase_gain_fine   = d[31:28];
                    next_state.shadow.phase_gain_coarse = d[27:24];
                    next_state.shadow.freq_gain_fine    = d[23:20];
                    next_state.shadow.freq_gain_coarse  = d[19:16];
                end
                llcc_pkg::ADDR_CLKOUT: begin
                    // Zero divisor would stall the pin clock; treat as one
                    next_state.clk_div    = (d[6:0] == 7'h00) ? 7'h01 : d[6:0];
                    next_state.sys_double = d[llcc_pkg::BIT_SYSDBL];
                end
                default: upd = 1'b0;    // Read-only or unmapped: ignored
            endcase
        end

        // Read back shadow view; update bit always zero
        if (rd) begin
            case (paddr)
                llcc_pkg::ADDR_ENABLE:
                    next_state.prdata = {29'h0, 1'b0, state.loop_hold_bit,
                                         state.loop_enable_bit};
                llcc_pkg::ADDR_REFLOCK: next_state.prdata = pack_reflock(state.shadow);
                llcc_pkg::ADDR_RATIO:
                    next_state.prdata = {state.shadow.fraction_denominator,
                                         state.shadow.fraction_numerator};
                llcc_pkg::ADDR_GAINS:   next_state.prdata = pack_gains(state.shadow);
                llcc_pkg::ADDR_CLKOUT:
                    next_state.prdata = {23'h0, state.sys_double, 1'b0, state.clk_div};
                llcc_pkg::ADDR_STATUS:
                    next_state.prdata = {24'h0, state.ctl.ref_index, state.ctl.ref_valid,
                                         state.ctl.free_run, state.ctl.feedback_on,
                                         state.ctl.run};
                default: next_state.pslverr = 1'b1;
            endcase
        end

        // Disabled loop tracks shadow; running loop waits for update
        if (!state.loop_enable_bit || (upd && state.loop_enable_bit))
            next_state.active = next_state.shadow;

        // Reference presence through three-stage synchroniser
        next_state.ref_q1 = ref_present;
        next_state.ref_q2 = state.ref_q1;
        next_state.ref_q3 = state.ref_q2;
        if (state.ref_q2 == state.ref_q3)
            next_state.ref_seen = state.ref_q3;

        // Source decode: reserved and no-input codes give no reference
        case (state.active.reference_source_select)
            llcc_pkg::SRC_MASTER_CLOCK_ONE: next_state.ctl.ref_index = 4'h1;
            llcc_pkg::SRC_PDM:   next_state.ctl.ref_index = 4'h2;
            llcc_pkg::SRC_SP1:   next_state.ctl.ref_index = 4'h3;
            llcc_pkg::SRC_SP2:   next_state.ctl.ref_index = 4'h4;
            default:             next_state.ctl.ref_index = 4'h0;
        endcase
        ref_ok = (next_state.ctl.ref_index != 4'h0) && state.ref_seen;
        next_state.ctl.ref_valid = ref_ok;

        // Feedback runs only when enabled, not held, reference present
        next_state.ctl.run         = state.loop_enable_bit;
        next_state.ctl.feedback_on = state.loop_enable_bit && !state.loop_hold_bit
                                     && ref_ok;
        next_state.ctl.free_run    = state.loop_enable_bit
                                     && (state.loop_hold_bit || !ref_ok);
        next_state.ctl.fd_fine_on  = state.active.freq_gain_fine
                                     != llcc_pkg::FD_FINE_OFF;

        // Pin clock: divide loop clock ticks by 1..127
        next_state.half_clk = 1'b0;
        if (!state.loop_enable_bit) begin
            next_state.div_cnt  = 7'h00;
            next_state.gpio_clk = 1'b0;
        end else if (state.clk_div == 7'h01) begin
            // Ratio one: a pin pulse per loop clock period
            next_state.div_cnt  = 7'h00;
            next_state.gpio_clk = loop_clk_tick;
        end else if (loop_clk_tick) begin
            if (state.div_cnt >= state.clk_div - 7'h01) begin
                next_state.div_cnt  = 7'h00;
                next_state.gpio_clk = 1'b1;
            end else begin
                next_state.div_cnt = state.div_cnt + 7'h01;
                if (state.div_cnt == (state.clk_div >> 1) - 7'h01)
                    next_state.gpio_clk = 1'b0;
            end
        end
        next_state.sys_clk_sel = state.sys_double;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                 <= '0;
            state.loop_enable_bit <= 1'b0;
            state.loop_hold_bit   <= 1'b1;
            state.sys_double      <= 1'b1;
            state.clk_div         <= llcc_pkg::RST_CLK_DIV;
            state.shadow          <= llcc_pkg::RST_CFG;
            state.active          <= llcc_pkg::RST_CFG;
            state.sys_clk_sel     <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs straight from flip-flops
    // ----------------------------------------------------------------
    assign pready         = state.pready;
    assign prdata         = state.prdata;
    assign pslverr        = state.pslverr;
    assign loop_cfg       = state.active;   // ratio = N + num/den
    assign loop_ctl       = state.ctl;
    assign gpio_clk_out   = state.gpio_clk;
    assign sys_clk_double = state.sys_clk_sel;

endmodule // llcc_top

/* llcc_pkg.sv */
// Purpose: Shared constants and types for the locked-loop configuration block
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   Register layout, reset values and field positions live here

package llcc_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_ENABLE   = 16'h1C00;
    localparam logic [15:0] ADDR_REFLOCK  = 16'h1C04;
    localparam logic [15:0] ADDR_RATIO    = 16'h1C08;
    localparam logic [15:0] ADDR_GAINS    = 16'h1C0C;
    localparam logic [15:0] ADDR_CLKOUT   = 16'h1C10;
    localparam logic [15:0] ADDR_STATUS   = 16'h1C14;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_ENABLE   = 0;
    localparam int BIT_HOLD     = 1;
    localparam int BIT_UPDATE   = 2;
    localparam int BIT_PHASEDET = 22;
    localparam int BIT_REFDET   = 21;
    localparam int BIT_LOCKDET  = 27;
    localparam int BIT_SYSDBL   = 8;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [3:0]  RST_LOCK_THR  = 4'h8;
    localparam logic [3:0]  RST_REF_SRC   = 4'h3;
    localparam logic [1:0]  RST_REF_DIV   = 2'h0;
    localparam logic [9:0]  RST_INT_MULT  = 10'h004;
    localparam logic [3:0]  RST_PD_FINE   = 4'h2;
    localparam logic [3:0]  RST_PD_COARSE = 4'h1;
    localparam logic [3:0]  RST_FD_FINE   = 4'hF;
    localparam logic [3:0]  RST_FD_COARSE = 4'h0;
    localparam logic [6:0]  RST_CLK_DIV   = 7'h01;

    // ----------------------------------------------------------------
    // Reference source, divider and gain codes
    // ----------------------------------------------------------------
    localparam logic [3:0] SRC_MASTER_CLOCK_ONE = 4'h0;
    localparam logic [3:0] SRC_NONE  = 4'h3;
    localparam logic [3:0] SRC_PDM   = 4'h5;
    localparam logic [3:0] SRC_SP1   = 4'h8;
    localparam logic [3:0] SRC_SP2   = 4'h9;
    localparam logic [1:0] DIV_BY_2  = 2'h1;
    localparam logic [3:0] FD_FINE_OFF = 4'hF;

    // Active loop configuration
    typedef struct packed {
        logic [3:0]  lock_detect_threshold;
        logic        lock_detect_enable;
        logic        phase_detect_enable;
        logic        reference_detect_enable;
        logic [1:0]  reference_divider;
        logic [3:0]  reference_source_select;
        logic [9:0]  integer_multiplier;
        logic [15:0] fraction_denominator;
        logic [15:0] fraction_numerator;
        logic [3:0]  phase_gain_fine;
        logic [3:0]  phase_gain_coarse;
        logic [3:0]  freq_gain_fine;
        logic [3:0]  freq_gain_coarse;
    } llcc_cfg_t;

    localparam llcc_cfg_t RST_CFG = '{
        lock_detect_threshold:   RST_LOCK_THR,
        lock_detect_enable:      1'b1,
        phase_detect_enable:     1'b0,
        reference_detect_enable: 1'b1,
        reference_divider:       RST_REF_DIV,
        reference_source_select: RST_REF_SRC,
        integer_multiplier:      RST_INT_MULT,
        fraction_denominator:    16'h0000,
        fraction_numerator:      16'h0000,
        phase_gain_fine:         RST_PD_FINE,
        phase_gain_coarse:       RST_PD_COARSE,
        freq_gain_fine:          RST_FD_FINE,
        freq_gain_coarse:        RST_FD_COARSE
    };

    // Loop controls handed to the analog core
    typedef struct packed {
        logic        run;
        logic        feedback_on;
        logic        free_run;
        logic        fd_fine_on;
        logic [3:0]  ref_index;
        logic        ref_valid;
    } llcc_ctl_t;

    // Complete block state
    typedef struct packed {
        logic        loop_enable_bit;
        logic        loop_hold_bit;
        logic        sys_double;
        logic [6:0]  clk_div;
        llcc_cfg_t   shadow;
        llcc_cfg_t   active;
        llcc_ctl_t   ctl;
        logic        ref_q1;
        logic        ref_q2;
        logic        ref_q3;
        logic        ref_seen;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic [6:0]  div_cnt;
        logic        gpio_clk;
        logic        half_clk;
        logic        sys_clk_sel;
    } llcc_state_t;

endpackage

/* llcc_asserts.sv */
// Purpose: Port-level checks of the loop configuration block
// Assumes: One clock domain, presetn asynchronous active low
// Notes:   Bound onto llcc_top below the module
`timescale 1ns/1ns
module llcc_asserts (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [15:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                pready,
    input wire logic [31:0]         prdata,
    input wire logic                pslverr,
    input wire logic                ref_present,
    input wire llcc_pkg::llcc_cfg_t loop_cfg,
    input wire llcc_pkg::llcc_ctl_t loop_ctl,
    input wire logic                sys_clk_double
);
    // ------------------------------------------------
    // Helpers and checks
    // ------------------------------------------------
    logic wr_ok;
    logic upd_ack;
    logic mapped;
    assign wr_ok   = psel && penable && pready && pwrite;
    assign upd_ack = wr_ok && paddr == llcc_pkg::ADDR_ENABLE && pwdata[2];
    assign mapped  = paddr inside {16'h1C00, 16'h1C04, 16'h1C08, 16'h1C0C,
                                   16'h1C10, 16'h1C14};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready not one cycle after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_ready_req: assert property (pready |-> psel && penable)
        else $error("ready without access");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside ready cycle");
    chk_err_map: assert property (pready |-> pslverr == !mapped)
        else $error("error flag does not match address map");
    chk_upd_zero: assert property (
        pready && !pwrite && paddr == llcc_pkg::ADDR_ENABLE |-> !prdata[2])
        else $error("update bit reads one");
    chk_cfg_frozen: assert property (
        loop_ctl.run && $past(loop_ctl.run) && $changed(loop_cfg) |-> $past(upd_ack))
        else $error("running config changed without update");
    chk_hold_free: assert property (
        loop_ctl.feedback_on |-> loop_ctl.run && !loop_ctl.free_run)
        else $error("feedback active while free running");
    chk_ref_lost: assert property (
        $fell(ref_present) && loop_ctl.run |-> ##[3:6] loop_ctl.free_run)
        else $error("loop not free running after reference loss");
    chk_double_wr: assert property (
        $changed(sys_clk_double) |-> $past(wr_ok && paddr == llcc_pkg::ADDR_CLKOUT, 2))
        else $error("clock doubling changed without write");
endmodule // llcc_asserts
bind llcc_top llcc_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ref_present(ref_present),
    .loop_cfg(loop_cfg), .loop_ctl(loop_ctl), .sys_clk_double(sys_clk_double));

/* llcc_ref_model.sv */
// Purpose: Reference source and loop clock beside the block
// Assumes: Loop clock keeps ticking while the reference is absent
// Notes:   ref_on from the bench starts and stops the reference
`timescale 1ns/1ns
module llcc_ref_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ref_on,
    output logic      ref_present,
    output logic      loop_clk_tick
);
    logic [1:0] cnt;
    // Reference presence and a tick every third cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt           <= 2'h0;
            ref_present   <= 1'b0;
            loop_clk_tick <= 1'b0;
        end else begin
            ref_present   <= ref_on;
            cnt           <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
            loop_clk_tick <= (cnt == 2'h2);
        end
    end
endmodule // llcc_ref_model

/* llcc_tb.sv */
// Purpose: Self-checking bench of the loop configuration block
// Assumes: APB master with one idle cycle between transfers
// Notes:   Seeded random field values mixed with corner cases
`timescale 1ns/1ns
module testbench;
    logic                pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0]         paddr = '0;
    logic [31:0]         pwdata = '0, rd, v;
    logic                pready, pslverr, er, ref_present, loop_clk_tick, ref_on = 1;
    logic [31:0]         prdata;
    logic                gpio_clk_out, sys_clk_double;
    llcc_pkg::llcc_cfg_t loop_cfg;
    llcc_pkg::llcc_ctl_t loop_ctl;
    logic [3:0]          srcs [6] = '{4'h3, 4'hA, 4'h0, 4'h5, 4'h8, 4'h9};
    int                  err_count = 0, check_count = 0, cyc = 0;
    time                 t0;
    localparam int       TICK_CYC = 3;         // Loop tick spacing of the model
    localparam int       CLK_NS   = 4;
    // Worked setting: 12 MHz reference, high band, fractional mode
    localparam longint   REF_HZ = 12000000;
    localparam longint   OUT_HZ = 49152000;

    llcc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .ref_present(ref_present),
        .loop_clk_tick(loop_clk_tick), .loop_cfg(loop_cfg), .loop_ctl(loop_ctl),
        .gpio_clk_out(gpio_clk_out), .sys_clk_double(sys_clk_double));
    llcc_ref_model u_ref (.pclk(pclk), .presetn(presetn), .ref_on(ref_on),
        .ref_present(ref_present), .loop_clk_tick(loop_clk_tick));

    // Clock and timeout
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    // ------------------------------------------------
    // Tasks and expectation functions
    // ------------------------------------------------
    function automatic logic [3:0] ref_idx(input logic [3:0] s);
        case (s)
            4'h0: return 4'h1;
            4'h5: return 4'h2;
            4'h8: return 4'h3;
            4'h9: return 4'h4;
            default: return 4'h0;
        endcase
    endfunction
    // Greatest common divisor of two frequencies in hertz
    function automatic longint gcd(input longint a, input longint b);
        longint r;
        while (b != 0) begin
            r = a % b;
            a = b;
            b = r;
        end
        return a;
    endfunction
    // Ratio word {denominator, numerator}; high band uses divider 1
    function automatic logic [31:0] ratio_word(input longint fr, input longint fo);
        longint g;
        g = gcd(fr, fo);
        return {16'(fr / g), 16'((fo % fr) / g)};
    endfunction
    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) begin
            err_count++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] ex);
        apb(0, a, 32'h0);
        cmp(nm, ex, rd);
    endtask
    task automatic settle();
        repeat (6) @(posedge pclk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        void'($urandom(64));
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rdc("enable_reg", llcc_pkg::ADDR_ENABLE, 32'h0000_0002);
        rdc("reflock_reg", llcc_pkg::ADDR_REFLOCK, 32'h8820_3004);
        rdc("ratio_reg", llcc_pkg::ADDR_RATIO, 32'h0000_0000);
        rdc("gains_reg", llcc_pkg::ADDR_GAINS, 32'h21F0_0000);
        rdc("clkout_reg", llcc_pkg::ADDR_CLKOUT, 32'h0000_0101);
        apb(0, 16'h1C18, 32'h0);
        cmp("unmapped_err", 32'h1, {31'h0, er});
        cmp("unmapped_data", 32'h0, rd);
        apb(1, 16'h1C18, 32'hFFFF_FFFF);
        cmp("unmapped_wr_err", 32'h1, {31'h0, er});
        $display("test reset done");
        // Disabled loop takes fields at once
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'hFFFF_FFFF : $urandom;
            apb(1, llcc_pkg::ADDR_RATIO, v);
            apb(1, llcc_pkg::ADDR_GAINS, v);
            apb(1, llcc_pkg::ADDR_REFLOCK, {22'h220800, v[9:0]});
            settle();
            cmp("numerator", v[15:0], loop_cfg.fraction_numerator);
            cmp("denominator", v[31:16], loop_cfg.fraction_denominator);
            cmp("multiplier", v[9:0], loop_cfg.integer_multiplier);
            cmp("gains", v[31:16], {loop_cfg.phase_gain_fine, loop_cfg.phase_gain_coarse,
                loop_cfg.freq_gain_fine, loop_cfg.freq_gain_coarse});
            cmp("fd_fine", {31'h0, v[23:20] != 4'hF}, loop_ctl.fd_fine_on);
        end
        $display("test direct config done");
        // Running loop in hold: shadow then update
        apb(1, llcc_pkg::ADDR_ENABLE, 32'h3);
        apb(1, llcc_pkg::ADDR_RATIO, ratio_word(REF_HZ, OUT_HZ));
        // Delay-mode and modulator bits sit outside this block
        apb(1, llcc_pkg::ADDR_GAINS, 32'h21F0_0000);
        foreach (srcs[i]) begin
            apb(1, llcc_pkg::ADDR_REFLOCK, {14'h2208, 1'b0, i[0], srcs[i], 2'h0,
                10'(OUT_HZ / REF_HZ)});
            settle();
            cmp("src_shadow", (i == 0) ? 4'h0 : srcs[i-1],
                loop_cfg.reference_source_select);
            apb(1, llcc_pkg::ADDR_ENABLE, 32'h7);
            settle();
            cmp("src_active", srcs[i], loop_cfg.reference_source_select);
            cmp("divider", i[0], loop_cfg.reference_divider);
            cmp("ref_index", ref_idx(srcs[i]), loop_ctl.ref_index);
            cmp("ref_valid", {31'h0, ref_idx(srcs[i]) != 4'h0}, loop_ctl.ref_valid);
            rdc("upd_readback", llcc_pkg::ADDR_ENABLE, 32'h3);
        end
        cmp("ratio_active", ratio_word(REF_HZ, OUT_HZ), {loop_cfg.fraction_denominator,
            loop_cfg.fraction_numerator});
        cmp("gains_active", 32'h0000_21F0, {16'h0, loop_cfg.phase_gain_fine,
            loop_cfg.phase_gain_coarse, loop_cfg.freq_gain_fine,
            loop_cfg.freq_gain_coarse});
        cmp("hold_fb", 32'h0, loop_ctl.feedback_on);
        cmp("hold_free", 32'h1, loop_ctl.free_run);
        rdc("status_reg", llcc_pkg::ADDR_STATUS, 32'h0000_004D);
        $display("test shadow update done");
        // Hold release, reference loss and return
        apb(1, llcc_pkg::ADDR_ENABLE, 32'h1);
        settle();
        cmp("lock_fb", 32'h1, loop_ctl.feedback_on);
        ref_on <= 0;
        repeat (10) @(posedge pclk);
        cmp("lost_free", 32'h1, loop_ctl.free_run);
        ref_on <= 1;
        repeat (10) @(posedge pclk);
        cmp("relock_fb", 32'h1, loop_ctl.feedback_on);
        $display("test reference loss done");
        // Pin clock divider and system clock choice
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'd127 : (i == 1) ? 32'd1 : 32'($urandom_range(1, 127));
            v[8] = i[0];
            apb(1, llcc_pkg::ADDR_CLKOUT, v);
            rdc("clkout_rb", llcc_pkg::ADDR_CLKOUT, v);
            cmp("sys_double", v[8], sys_clk_double);
            // Rise to rise of the pin clock, in pclk cycles
            @(posedge gpio_clk_out);
            t0 = $time;
            @(posedge gpio_clk_out);
            cmp("gpio_period", TICK_CYC * v[6:0], 32'(($time - t0) / CLK_NS));
        end
        $display("test clock out done");
        // Stopped reference: hold set before the loop is disabled
        ref_on <= 0;
        apb(1, llcc_pkg::ADDR_ENABLE, 32'h3);
        apb(1, llcc_pkg::ADDR_ENABLE, 32'h2);
        settle();
        cmp("disabled_run", 32'h0, loop_ctl.run);
        cmp("disabled_gpio", 32'h0, gpio_clk_out);
        $display("test disable done");
        stop_test();
    end
endmodule // testbench
